// file: rtl/ispp_pkg.sv
// Purpose: Shared constants for the sensor pixel output port.
// Assumes: A 25 MHz master clock; the pixel clock is half of it.
// Notes:   Timing counts are derived from times in their own units.
package ispp_pkg;

  // Clocking
  localparam int CLK_HZ       = 25_000_000;
  localparam int PIX_DIV      = 2;
  localparam int PIX_PERIOD_NS = PIX_DIV * 1_000_000_000 / CLK_HZ;

  // Pixel word and counter widths
  localparam int PIX_W   = 12;
  localparam int COL_W   = 12;
  localparam int ROW_W   = 11;
  localparam int TIMER_W = 21;

  // Default full-resolution image and blanking
  localparam int ACTIVE_COLS   = 2592;
  localparam int ACTIVE_ROWS   = 1944;
  localparam int H_BLANK_TICKS = 64;
  localparam int V_BLANK_LINES = 8;

  // Frame rate: period in ns, then in pixel clock ticks (rounded down)
  localparam int FRAME_RATE_FPS     = 12;
  localparam int FRAME_PERIOD_NS    = 1_000_000_000 / FRAME_RATE_FPS;
  localparam int FRAME_PERIOD_TICKS = FRAME_PERIOD_NS / PIX_PERIOD_NS;

  // Timed snapshot exposure length
  localparam int EXPOSURE_NS    = 80_000;
  localparam int EXPOSURE_TICKS = EXPOSURE_NS / PIX_PERIOD_NS;

  // Serial bus device addresses; values are arbitrary
  localparam logic [7:0] ADDR_SEL_HIGH = 8'h5c;
  localparam logic [7:0] ADDR_SEL_LOW  = 8'h26;

  // Pin synchroniser lanes and their reset levels
  localparam int SYNC_W = 7;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 7'h03;
  localparam int S_OE_B     = 0;
  localparam int S_STBY_B   = 1;
  localparam int S_TRIG     = 2;
  localparam int S_ADDR     = 3;
  localparam int S_SNAP     = 4;
  localparam int S_BULB     = 5;
  localparam int S_ALLROWS  = 6;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXPOSE,
    ST_ACTIVE,
    ST_VBLANK
  } ispp_state_t;

endpackage : ispp_pkg

// file: rtl/ispp_sync.sv
// Purpose: Two-flop synchroniser for a group of pin levels.
// Assumes: Each lane is an independent level; no bus coherence.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none
module ispp_sync #(
  parameter int                 WIDTH     = 1,
  parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // Shift pins through two stages
  always_comb begin
    meta_next = d_in;
    sync_next = meta_reg;
  end

  // Reset loads the idle level of each pin
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign q_out = sync_reg;

endmodule : ispp_sync
`default_nettype wire

// file: rtl/ispp_top.sv
// Purpose: Frame timing, exposure control and pixel output of the sensor.
// Assumes: Pins are asynchronous to CLOCK_IN; all but the reset pin pass two flops first.
// Notes:   Pixel clock is CLOCK_IN / 2; pixel data and flags launch on its rising edge.
// How it works
// - Low reset pin resets everything immediately to idle levels
// - High enable pin floats all pixel outputs
// - Low standby pin freezes clocks and frames
// - Snapshot: one frame per capture request made while idle
// - Bulb: falling capture request ends exposure
// - Address pin selects one of two addresses
// - Twelve-bit pixel, MSB on bit eleven
// - Frame flag covers active lines and their horizontal blanking
// - Default frame 2592 by 1944; readout outlasts the 12fps period, giving about 2.4fps
// - All-rows release exposes every row together in snapshot mode
// - Line flag high only for active pixels
// - One pixel per pixel clock, valid when both flags
// - Pixel data and flags change on rising pixel clock edge; the address follows its pin every clock
// - Flash flag high while all rows expose
`timescale 1ns/100ps
`default_nettype none
module ispp_top
  import ispp_pkg::*;
#(
  parameter int FRAME_TICKS = FRAME_PERIOD_TICKS,
  parameter int COLS        = ACTIVE_COLS,
  parameter int ROWS        = ACTIVE_ROWS
) (
  input  wire logic             CLOCK_IN,
  input  wire logic             RST_B_IN,
  input  wire logic             OUTPUT_ENABLE_B_IN,
  input  wire logic             LOW_POWER_REQUEST_B_IN,
  input  wire logic             CAPTURE_REQUEST_IN,
  input  wire logic             BUS_ADDRESS_SELECT_IN,
  input  wire logic             SNAPSHOT_MODE_IN,
  input  wire logic             BULB_MODE_IN,
  input  wire logic             ALL_ROWS_RELEASE_IN,
  output logic                  PIXEL_CLOCK_OUT,
  output logic      [PIX_W-1:0] PIXEL_DATA_OUT,
  output logic                  FRAME_ACTIVE_OUT,
  output logic                  LINE_ACTIVE_OUT,
  output logic                  EXPOSURE_FLASH_OUT,
  output logic                  OUTPUTS_OE_B_OUT,
  output logic      [7:0]       DEVICE_ADDRESS_OUT
);

  localparam logic [COL_W-1:0]   LINE_LAST  = COL_W'(COLS + H_BLANK_TICKS - 1);
  localparam logic [COL_W-1:0]   COLS_W     = COL_W'(COLS);
  localparam logic [ROW_W-1:0]   ROW_LAST   = ROW_W'(ROWS - 1);
  localparam logic [ROW_W-1:0]   VBL_LAST   = ROW_W'(V_BLANK_LINES - 1);
  localparam logic [TIMER_W-1:0] FRAME_LAST = TIMER_W'(FRAME_TICKS - 1);
  localparam logic [TIMER_W-1:0] EXPO_LAST  = TIMER_W'(EXPOSURE_TICKS - 1);

  logic [SYNC_W-1:0] pins_s;
  logic              awake;
  logic              tick;
  logic              trig_rise;
  logic              trig_fall;

  ispp_state_t       state_reg, state_next;
  logic              phase_reg, phase_next;
  logic [COL_W-1:0]  col_reg, col_next;
  logic [ROW_W-1:0]  row_reg, row_next;
  logic [TIMER_W-1:0] timer_reg, timer_next;
  logic              trig_d_reg, trig_d_next;
  logic [PIX_W-1:0]  data_reg, data_next;
  logic              frame_reg, frame_next;
  logic              line_reg, line_next;
  logic              flash_reg, flash_next;
  logic [7:0]        addr_reg, addr_next;

  // Every pin level but the reset pin crosses into the CLOCK_IN domain first
  ispp_sync #(
    .WIDTH     (SYNC_W),
    .RESET_VAL (SYNC_RESET)
  ) u_pin_sync (
    .clk_in   (CLOCK_IN),
    .rst_b_in (RST_B_IN),
    .d_in     ({ALL_ROWS_RELEASE_IN, BULB_MODE_IN, SNAPSHOT_MODE_IN,
                BUS_ADDRESS_SELECT_IN, CAPTURE_REQUEST_IN,
                LOW_POWER_REQUEST_B_IN, OUTPUT_ENABLE_B_IN}),
    .q_out    (pins_s)
  );

  // Standby gates the pixel clock; tick is the rising pixel clock edge
  assign awake     = pins_s[S_STBY_B];
  assign tick      = awake && !phase_reg;
  assign trig_rise = pins_s[S_TRIG] && !trig_d_reg;
  assign trig_fall = !pins_s[S_TRIG] && trig_d_reg;

  // Frame sequencer; trigger edges are judged on pixel ticks only
  always_comb begin
    state_next  = state_reg;
    col_next    = col_reg;
    row_next    = row_reg;
    timer_next  = timer_reg;
    trig_d_next = trig_d_reg;
    phase_next  = awake ? !phase_reg : 1'b0;
    if (tick) begin
      trig_d_next = pins_s[S_TRIG];
      // Saturate so an idle sensor never wraps into a false period
      if (timer_reg != '1) begin
        timer_next = timer_reg + 1'b1;
      end
      unique case (state_reg)
        ST_IDLE: begin
          if (!pins_s[S_SNAP]) begin
            if (timer_reg >= FRAME_LAST) begin
              state_next = ST_ACTIVE;
              timer_next = '0;
              col_next   = '0;
              row_next   = '0;
            end
          end else if (trig_rise) begin
            timer_next = '0;
            col_next   = '0;
            row_next   = '0;
            if (pins_s[S_ALLROWS] || pins_s[S_BULB]) begin
              state_next = ST_EXPOSE;
            end else begin
              state_next = ST_ACTIVE;
            end
          end
        end
        ST_EXPOSE: begin
          if (pins_s[S_BULB] ? trig_fall
                             : (timer_reg >= EXPO_LAST)) begin
            state_next = ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          col_next = col_reg + 1'b1;
          if (col_reg == LINE_LAST) begin
            col_next = '0;
            row_next = row_reg + 1'b1;
            if (row_reg == ROW_LAST) begin
              row_next   = '0;
              state_next = ST_VBLANK;
            end
          end
        end
        ST_VBLANK: begin
          col_next = col_reg + 1'b1;
          if (col_reg == LINE_LAST) begin
            col_next = '0;
            row_next = row_reg + 1'b1;
            if (row_reg == VBL_LAST) begin
              row_next   = '0;
              state_next = ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Output words launched together on a pixel tick; the address follows its pin every clock
  always_comb begin
    frame_next = frame_reg;
    line_next  = line_reg;
    data_next  = data_reg;
    flash_next = flash_reg;
    addr_next  = pins_s[S_ADDR] ? ADDR_SEL_HIGH : ADDR_SEL_LOW;
    if (tick) begin
      frame_next = (state_reg == ST_ACTIVE);
      line_next  = (state_reg == ST_ACTIVE) && (col_reg < COLS_W);
      // Test ramp stands in for the converter; zero in blanking
      data_next  = line_next ? PIX_W'(col_reg + COL_W'(row_reg))
                             : '0;
      // Flag follows the state being entered, so it drops as readout begins
      flash_next = (state_next == ST_EXPOSE) && pins_s[S_ALLROWS];
    end
  end

  // Reset pin acts at once, without waiting for a clock
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      state_reg  <= ST_IDLE;
      phase_reg  <= 1'b0;
      col_reg    <= '0;
      row_reg    <= '0;
      timer_reg  <= '0;   // Wait a period so mode pins settle first
      trig_d_reg <= 1'b0;
      data_reg   <= '0;
      frame_reg  <= 1'b0;
      line_reg   <= 1'b0;
      flash_reg  <= 1'b0;
      addr_reg   <= ADDR_SEL_LOW;
    end else begin
      state_reg  <= state_next;
      phase_reg  <= phase_next;
      col_reg    <= col_next;
      row_reg    <= row_next;
      timer_reg  <= timer_next;
      trig_d_reg <= trig_d_next;
      data_reg   <= data_next;
      frame_reg  <= frame_next;
      line_reg   <= line_next;
      flash_reg  <= flash_next;
      addr_reg   <= addr_next;
    end
  end

  // Outputs; the pad ring floats them when the enable pin is high
  assign PIXEL_CLOCK_OUT    = phase_reg;
  assign PIXEL_DATA_OUT     = data_reg;
  assign FRAME_ACTIVE_OUT   = frame_reg;
  assign LINE_ACTIVE_OUT    = line_reg;
  assign EXPOSURE_FLASH_OUT = flash_reg;
  assign OUTPUTS_OE_B_OUT   = pins_s[S_OE_B];
  assign DEVICE_ADDRESS_OUT = addr_reg;

  // Checking helpers: pixels per line and lines per frame
  logic [COL_W-1:0] chk_pix_reg;
  logic [ROW_W-1:0] chk_lines_reg;
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      chk_pix_reg   <= '0;
      chk_lines_reg <= '0;
    end else begin
      chk_pix_reg   <= !line_reg ? '0 :
                       chk_pix_reg + COL_W'(phase_reg);
      chk_lines_reg <= !frame_reg ? '0 :
                       chk_lines_reg + ROW_W'(line_reg && !line_next);
    end
  end

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_B_IN);

  a_oe_floats: assert property (OUTPUT_ENABLE_B_IN [*3] |-> OUTPUTS_OE_B_OUT)
    else $error("Outputs still driven with enable pin high");
  a_standby_frozen: assert property (!LOW_POWER_REQUEST_B_IN [*5]
      |-> !PIXEL_CLOCK_OUT && $stable(PIXEL_DATA_OUT) && $stable(state_reg))
    else $error("Activity seen during standby");
  a_addr_select: assert property (BUS_ADDRESS_SELECT_IN [*4]
      |-> DEVICE_ADDRESS_OUT == ADDR_SEL_HIGH)
    else $error("Wrong bus address for high select pin");
  a_line_in_frame: assert property (LINE_ACTIVE_OUT |-> FRAME_ACTIVE_OUT)
    else $error("Line flag outside frame flag");
  a_launch_rising: assert property (($changed(PIXEL_DATA_OUT)
      || $changed(FRAME_ACTIVE_OUT) || $changed(LINE_ACTIVE_OUT)
      || $changed(EXPOSURE_FLASH_OUT)) |-> $rose(PIXEL_CLOCK_OUT))
    else $error("Output changed away from rising pixel clock");
  a_line_width: assert property ($fell(LINE_ACTIVE_OUT)
      |-> chk_pix_reg == COLS_W)
    else $error("Line did not hold the full pixel count");
  a_frame_rows: assert property ($fell(FRAME_ACTIVE_OUT)
      |-> chk_lines_reg == ROW_W'(ROWS))
    else $error("Frame did not hold the full row count");
  a_flash_no_read: assert property (EXPOSURE_FLASH_OUT
      |-> !FRAME_ACTIVE_OUT && state_reg == ST_EXPOSE)
    else $error("Flash flag outside simultaneous exposure");
  a_flash_to_read: assert property ($fell(EXPOSURE_FLASH_OUT)
      |-> ##[0:4] FRAME_ACTIVE_OUT)
    else $error("Readout did not follow global exposure");
  a_snap_on_demand: assert property ((state_reg == ST_IDLE
      && state_next != ST_IDLE && pins_s[S_SNAP]) |-> trig_rise)
    else $error("Snapshot frame started without a request");
  a_bulb_end: assert property ((state_reg == ST_EXPOSE
      && state_next == ST_ACTIVE && pins_s[S_BULB]) |-> trig_fall)
    else $error("Bulb exposure ended without request release");

  c_line_done: cover property ($fell(LINE_ACTIVE_OUT));
  c_snapshot: cover property (pins_s[S_SNAP] && $rose(FRAME_ACTIVE_OUT));
  c_flash: cover property ($fell(EXPOSURE_FLASH_OUT));
  c_standby: cover property (!awake [*4] ##1 awake);

endmodule : ispp_top
`default_nettype wire

// file: verif/ispp_host_model.sv
// Purpose: Host capture model that latches the resolved pixel port pins.
// Assumes: Floating pins arrive as z; counters clear on clr_in.
// Notes:   The bench judges the counts; the model only gathers them.
`timescale 1ns/100ps
`default_nettype none
module ispp_host_model
  import ispp_pkg::*;
(
  input  wire logic             pclk_in,
  input  wire logic [PIX_W-1:0] data_in,
  input  wire logic             fv_in,
  input  wire logic             lv_in,
  input  wire logic             flash_in,
  input  wire logic             clr_in,
  output var int                frames_out,
  output var int                cols_out,
  output var int                rows_out,
  output var int                hblank_out,
  output var int                flash_out,
  output var int                errs_out
);
  int   col;
  int   row;
  logic lv_d;
  logic fv_d;
  // Latch half a pixel after launch, so no race with the rising edge
  always @(negedge pclk_in or posedge clr_in) begin
    if (clr_in) begin
      frames_out = 0;
      hblank_out = 0;
      flash_out = 0;
      errs_out = 0;
      col = 0;
      row = 0;
    end else begin
      if (fv_in === 1'b1 && fv_d !== 1'b1) begin
        row = 0;
        hblank_out = 0;
      end
      // Only words with both flags high are pixels
      if (fv_in === 1'b1 && lv_in === 1'b1) begin
        if (data_in !== PIX_W'(col + row)) errs_out++;
        col++;
      end
      if (fv_in === 1'b1 && lv_in === 1'b0) hblank_out++;
      if (lv_in === 1'b1 && fv_in !== 1'b1) errs_out++;
      if (lv_d === 1'b1 && lv_in !== 1'b1) begin
        cols_out = col;
        col = 0;
        row++;
      end
      if (fv_d === 1'b1 && fv_in !== 1'b1) begin
        rows_out = row;
        frames_out++;
      end
      // Flash must never overlap readout
      if (flash_in === 1'b1) begin
        flash_out++;
        if (fv_in === 1'b1) errs_out++;
      end
      lv_d = lv_in;
      fv_d = fv_in;
    end
  end
endmodule : ispp_host_model
`default_nettype wire

// file: verif/ispp_top_tb_top.sv
// Purpose: Self-checking bench for the sensor pixel output port.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes:   Small frame parameters keep the run short.
`timescale 1ns/100ps
`default_nettype none
module ispp_top_tb_top
  import ispp_pkg::*;
;
  localparam int C = 8;
  localparam int R = 4;
  logic clk = 0, rst_b = 1, oe_b = 0, stby_b = 1, trig = 0;
  logic asel = 0, snap = 0, bulb = 0, allr = 0, clr = 0;
  logic pclk, fv, lv, fl, oeo;
  logic [PIX_W-1:0] pd;
  logic [7:0] addr;
  int frames, cols, rows, hb, flash, errs, hi;
  int n_fail = 0, checked = 0, cyc = 0;
  // Pins float while the synced enable is high
  wire logic p_w = oeo ? 1'bz : pclk;
  wire logic f_w = oeo ? 1'bz : fv;
  wire logic l_w = oeo ? 1'bz : lv;
  wire logic s_w = oeo ? 1'bz : fl;
  wire logic [PIX_W-1:0] d_w = oeo ? 12'hzzz : pd;
  // Clock at 25 MHz
  always #20 clk = ~clk;
  ispp_top #(.FRAME_TICKS(50), .COLS(C), .ROWS(R)) u_dut (
    .CLOCK_IN(clk), .RST_B_IN(rst_b), .OUTPUT_ENABLE_B_IN(oe_b),
    .LOW_POWER_REQUEST_B_IN(stby_b), .CAPTURE_REQUEST_IN(trig),
    .BUS_ADDRESS_SELECT_IN(asel), .SNAPSHOT_MODE_IN(snap),
    .BULB_MODE_IN(bulb), .ALL_ROWS_RELEASE_IN(allr),
    .PIXEL_CLOCK_OUT(pclk), .PIXEL_DATA_OUT(pd), .FRAME_ACTIVE_OUT(fv),
    .LINE_ACTIVE_OUT(lv), .EXPOSURE_FLASH_OUT(fl),
    .OUTPUTS_OE_B_OUT(oeo), .DEVICE_ADDRESS_OUT(addr));
  ispp_host_model u_host (
    .pclk_in(p_w), .data_in(d_w), .fv_in(f_w), .lv_in(l_w),
    .flash_in(s_w), .clr_in(clr), .frames_out(frames), .cols_out(cols),
    .rows_out(rows), .hblank_out(hb), .flash_out(flash), .errs_out(errs));
  task automatic finish_test;
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic clear_host;
    clr = 1;
    step(1);
    clr = 0;
  endtask : clear_host
  task automatic count_hi(input int n);
    hi = 0;
    repeat (n) begin
      step(1);
      hi += (p_w === 1'b1);
    end
  endtask : count_hi
  task automatic wait_frames(input int n, input int lim);
    for (int i = 0; i < lim && frames < n; i++) step(1);
    chk("frames", n, frames);
  endtask : wait_frames
  task automatic pulse;
    trig = 1;
    step(8);
    trig = 0;
  endtask : pulse
  // Reset acts before any clock edge; address pin sets it after release
  task automatic do_reset;
    rst_b = 0;
    #5;
    chk("rst_pclk", 0, pclk);
    chk("rst_fv", 0, fv);
    chk("rst_oe", 1, oeo);
    chk("rst_addr", 8'h26, addr);
    step(6);
    rst_b = 1;
    step(4);
    chk("addr", asel ? 8'h5c : 8'h26, addr);
    clear_host();
  endtask : do_reset
  task automatic t_address;
    asel = 0;
    step(5);
    chk("addr_low", 8'h26, addr);
    asel = 1;
    step(5);
    chk("addr_high", 8'h5c, addr);
  endtask : t_address
  // Free-running readout: skip the first frame after reset, judge the next
  task automatic t_continuous;
    wait_frames(1, 3000);
    clear_host();
    wait_frames(1, 3000);
    chk("cols", C, cols);
    chk("rows", R, rows);
    chk("hblank", R * H_BLANK_TICKS, hb);
    chk("errs", 0, errs);
  endtask : t_continuous
  task automatic t_standby;
    stby_b = 0;
    step(4);
    count_hi(40);
    chk("stby_pclk", 0, hi);
    stby_b = 1;
    step(4);
    count_hi(10);
    chk("wake_pclk", 5, hi);
  endtask : t_standby
  task automatic t_oe;
    oe_b = 1;
    step(4);
    chk("float", {16'h0, 16'hzzzz}, {16'h0, p_w, f_w, l_w, s_w, d_w});
    oe_b = 0;
    step(4);
    count_hi(10);
    chk("drive_pclk", 5, hi);
  endtask : t_oe
  // Second request lands mid-frame and must not queue a frame
  task automatic t_snapshot;
    snap = 1;
    do_reset();
    step(20);
    chk("no_request", 0, frames);
    pulse();
    step(200);
    pulse();
    step(3600);
    chk("snap_frames", 1, frames);
    chk("snap_rows", R, rows);
    chk("snap_flash", 0, flash);
  endtask : t_snapshot
  task automatic t_global;
    allr = 1;
    do_reset();
    pulse();
    wait_frames(1, 5000);
    chk("flash_len", EXPOSURE_TICKS, flash);
    chk("errs", 0, errs);
  endtask : t_global
  task automatic t_bulb;
    bulb = 1;
    do_reset();
    trig = 1;
    step(600);
    trig = 0;
    step(8);
    chk("bulb_end", 0, s_w);
    chk("bulb_len", 1, flash >= 297 && flash <= 303);
    wait_frames(1, 3000);
  endtask : t_bulb
  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      finish_test();
    end
  end
  // Main sequence
  initial begin
    // Let every process arm, so the reset pin gives a real falling edge
    #1;
    do_reset();
    t_address();
    t_continuous();
    t_standby();
    t_oe();
    t_snapshot();
    t_global();
    t_bulb();
    finish_test();
  end
endmodule : ispp_top_tb_top
`default_nettype wire
